/* core/hcm_regs.svh */
// register map, fields, reset values, timing counts of the current monitor
// assumes byte addresses, one 32-bit word per register
`ifndef HCM_REGS_SVH
`define HCM_REGS_SVH

`define HCM_ADDR_CTRL      8'h00
`define HCM_ADDR_RATIO     8'h04
`define HCM_ADDR_PHSEL     8'h08
`define HCM_ADDR_STATUS    8'h0c
`define HCM_ADDR_MASK      8'h10
`define HCM_ADDR_ALARM     8'h14
`define HCM_ADDR_LIMIT0    8'h20
`define HCM_ADDR_READING0  8'h40
`define HCM_IDX_LIMIT      3'h1
`define HCM_IDX_READING    3'h2

`define HCM_CTRL_IVL_LSB   0
`define HCM_CTRL_IVL_MSB   11
`define HCM_CTRL_ENER_LSB  12
`define HCM_CTRL_ENER_MSB  19
`define HCM_CTRL_DIR_BIT   20
`define HCM_ALARM_SLOT_LSB 9

`define HCM_RST_IVL        12'h00a
`define HCM_RST_ENER       8'h02
`define HCM_RST_RATIO      16'h03e8
`define HCM_LIMIT_OFF      16'h8300
`define HCM_IVL_MIN        12'h001
`define HCM_IVL_MAX        12'hbb8
`define HCM_ENER_MIN       8'h02
`define HCM_ENER_MAX       8'hff

`define HCM_OUTPUTS        8
`define HCM_SHORT_SLOT     4'h8
`define HCM_VNOM           9'h080
`define HCM_VSCALE_SH      7
`define HCM_LIMIT_UA       48'sh0000000186a0

`define HCM_CLK_MHZ        100
`define HCM_WINDOW_MS      100
`define HCM_WINDOW_CYC     (`HCM_WINDOW_MS * 1000 * `HCM_CLK_MHZ)
`define HCM_WINDOWS_PER_S  4'h9

`define HCM_RESP_OKAY      2'h0
`define HCM_RESP_SLVERR    2'h2

`endif

/* core/hcm_pkg.sv */
// types of the current monitor
// assumes hcm_regs.svh for the numbers
package hcm_pkg;

    typedef enum logic [2:0] {
        HCM_IDLE   = 3'b001,
        HCM_SETTLE = 3'b010,
        HCM_SAMPLE = 3'b100
    } hcm_phase_t;

    // phase voltages, 0x80 = nominal, one lsb = 1/128 of nominal
    typedef struct packed {
        logic [2:0][7:0] line;
    } hcm_phase_volt_t;

    typedef struct packed {
        logic [23:0] cnt;
        logic [3:0]  dec;
        logic        t100;
        logic        t1s;
    } hcm_div_state_t;

    typedef struct packed {
        hcm_phase_t        phase;
        logic [3:0]        slot;
        logic [11:0]       sec_cnt;
        logic [7:0]        unit_cnt;
        logic [15:0]       peak;
        logic [7:0]        drv;
        logic [11:0]       ivl;
        logic [7:0]        ener;
        logic              dir;
        logic [15:0]       ratio;
        logic [7:0][1:0]   phsel;
        logic [9:0]        mask;
        logic [9:0]        status;
        logic [7:0][15:0]  limit;
        logic [7:0][31:0]  reading;
        logic [7:0]        heat_alarm;
        logic              short_alarm;
        logic              aw_held;
        logic [7:0]        aw_addr;
        logic              w_held;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } hcm_state_t;

endpackage

/* core/hcm_tick_div.sv */
// divider: 100 ms and 1 s pulses from clk
// assumes srst sync, active high
`timescale 1ns/1ns
`default_nettype none
`include "hcm_regs.svh"

module hcm_tick_div #(
    parameter int unsigned CYC_100MS = `HCM_WINDOW_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // ticks
    output logic      tick_100ms,
    output logic      tick_1s
);

    hcm_pkg::hcm_div_state_t s;
    hcm_pkg::hcm_div_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.t100 = 1'b0;
        next_s.t1s  = 1'b0;
        if (s.cnt == 24'(CYC_100MS - 1)) begin
            next_s.cnt  = '0;
            next_s.t100 = 1'b1;
            // 1 s pulse always coincides with a 100 ms pulse
            if (s.dec == `HCM_WINDOWS_PER_S) begin
                next_s.dec = '0;
                next_s.t1s = 1'b1;
            end else begin
                next_s.dec = s.dec + 4'h1;
            end
        end else begin
            next_s.cnt = s.cnt + 24'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_100ms = s.t100;
    assign tick_1s    = s.t1s;

endmodule
`default_nettype wire

/* core/hcm_monitor.sv */
// heating current monitor: slot sequencer, output gating, scaling, alarms, AXI4-Lite registers
// assumes inputs synchronous to clk; srst sync, active high
//
// Overview of operation
// - one measurement each time the interval in seconds expires
// - rotate eight output slots plus one short-circuit slot
// - during a slot force all other monitored outputs off
// - energize the tested output for the duty time, 100 ms units, min 200 ms
// - settle first, sample only during the final 100 ms window
// - direction bit selects overload or interruption alarm
// - short-circuit check runs in both alarm directions
// - reading equals transformer current times configured ratio
// - phase selector: 0 no correction, 1 to 3 select a phase voltage
// - correction follows selected phase voltage deviation, both ways
// - short slot: all monitored outputs off, any current raises the short alarm
// - one interval and one duty time shared by all outputs
// - interval accepted 1 to 3000 s, default 10
// - duty count accepted 2 to 255, default 2
// - per-output limit, value -32000 switches the limit off
// - only outputs with monitor enable set are measured
`timescale 1ns/1ns
`default_nettype none
`include "hcm_regs.svh"

module hcm_monitor #(
    parameter int unsigned TICK_CYCLES = `HCM_WINDOW_CYC
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // axi4-lite write address and data
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    // axi4-lite write response
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    output logic [1:0]                    s_axi_bresp,
    // axi4-lite read
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    input  wire logic [7:0]               s_axi_araddr,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    // heater outputs
    input  wire logic [7:0]               drive_in,
    input  wire logic [7:0]               monitor_enable_n,
    output logic [7:0]                    drive_out,
    // transformer input, microamps
    input  wire logic                     ct_valid,
    input  wire logic [15:0]              ct_current_ua,
    input  wire hcm_pkg::hcm_phase_volt_t voltage_correction_line,
    // results
    output logic [7:0]                    current_alarm,
    output logic                          shorted_switch_alarm,
    output logic                          irq
);

    hcm_pkg::hcm_state_t s;
    hcm_pkg::hcm_state_t next_s;
    logic                tick_100ms;
    logic                tick_1s;
    logic [11:0]         ivl_eff;
    logic [7:0]          ener_eff;
    logic [31:0]         raw;
    logic [8:0]          vfac;
    logic [40:0]         corr_wide;
    logic [31:0]         corr;
    logic [31:0]         ctrl_m;
    logic signed [47:0]  lim_ua;
    logic signed [47:0]  rd_s;
    logic [9:0]          ev;
    logic [3:0]          nslot;
    logic                any_en;

    hcm_tick_div #(
        .CYC_100MS (TICK_CYCLES)
    ) u_div (
        .clk        (clk),
        .srst       (srst),
        .tick_100ms (tick_100ms),
        .tick_1s    (tick_1s)
    );

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lo,
                                            input logic [11:0] hi);
        clamp12 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // wstrb lanes merged into old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    // bank index of an address
    function automatic logic [2:0] bank(input logic [7:0] a);
        bank = a[7:5];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    assign ivl_eff  = clamp12(s.ivl, `HCM_IVL_MIN, `HCM_IVL_MAX);
    assign ener_eff = 8'(clamp12({4'h0, s.ener}, {4'h0, `HCM_ENER_MIN},
                                 {4'h0, `HCM_ENER_MAX}));
    assign any_en   = |monitor_enable_n;
    assign nslot    = (s.slot == `HCM_SHORT_SLOT) ? 4'h0 : s.slot + 4'h1;
    // ctrl word as the pending write leaves it
    assign ctrl_m   = merge({11'h0, s.dir, s.ener, s.ivl}, s.wdata, s.wstrb);

    // peak scaling
    always_comb begin
        raw       = s.peak * s.ratio;
        vfac      = `HCM_VNOM;
        if (s.slot < `HCM_SHORT_SLOT && s.phsel[s.slot[2:0]] != 2'h0) begin
            // first order: 1 % low voltage lifts reading 1 %
            vfac = 9'h100 - {1'b0, voltage_correction_line.line[s.phsel[s.slot[2:0]] - 2'h1]};
        end
        corr_wide = raw * vfac;
        corr      = (|corr_wide[40:39]) ? 32'hffff_ffff : corr_wide[38:7];
        lim_ua    = 48'(signed'(s.limit[s.slot[2:0]])) * `HCM_LIMIT_UA;
        rd_s      = signed'({16'h0, corr});
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s = s;
        ev     = '0;

        // sequencer
        unique case (s.phase)
            hcm_pkg::HCM_IDLE: begin
                if (tick_1s) begin
                    if (s.sec_cnt + 12'h1 >= ivl_eff) begin
                        next_s.sec_cnt  = '0;
                        next_s.unit_cnt = '0;
                        next_s.peak     = '0;
                        // disabled slot passes unmeasured
                        if (s.slot == `HCM_SHORT_SLOT ? any_en : monitor_enable_n[s.slot[2:0]]) begin
                            next_s.phase = hcm_pkg::HCM_SETTLE;
                        end else begin
                            next_s.slot = nslot;
                        end
                    end else begin
                        next_s.sec_cnt = s.sec_cnt + 12'h1;
                    end
                end
            end
            hcm_pkg::HCM_SETTLE: begin
                // starts on a 1 s tick: units are whole windows
                if (tick_100ms) begin
                    next_s.unit_cnt = s.unit_cnt + 8'h1;
                    if (s.unit_cnt + 8'h2 >= ener_eff) begin
                        next_s.phase = hcm_pkg::HCM_SAMPLE;
                    end
                end
            end
            hcm_pkg::HCM_SAMPLE: begin
                if (ct_valid && ct_current_ua > s.peak) begin
                    next_s.peak = ct_current_ua;
                end
                if (tick_100ms) begin
                    next_s.phase = hcm_pkg::HCM_IDLE;
                    next_s.slot  = nslot;
                    if (s.slot == `HCM_SHORT_SLOT) begin
                        // either alarm direction
                        next_s.short_alarm = (s.peak != 16'h0);
                        ev[8]              = (s.peak != 16'h0);
                    end else begin
                        next_s.reading[s.slot[2:0]] = corr;
                        if (s.limit[s.slot[2:0]] == `HCM_LIMIT_OFF) begin
                            next_s.heat_alarm[s.slot[2:0]] = 1'b0;
                        end else if (s.dir) begin
                            next_s.heat_alarm[s.slot[2:0]] = rd_s > lim_ua;
                        end else begin
                            next_s.heat_alarm[s.slot[2:0]] = rd_s < lim_ua;
                        end
                        ev[s.slot[2:0]] = next_s.heat_alarm[s.slot[2:0]];
                    end
                    ev[9] = 1'b1;
                end
            end
            default: begin
                next_s.phase = hcm_pkg::HCM_IDLE;
            end
        endcase

        // output gating, registered
        next_s.drv = drive_in;
        if (next_s.phase != hcm_pkg::HCM_IDLE) begin
            for (int i = 0; i < `HCM_OUTPUTS; i++) begin
                if (monitor_enable_n[i]) begin
                    next_s.drv[i] = (next_s.slot == 4'(i));
                end
            end
        end

        // axi write: aw and w in either order
        if (s_axi_awvalid && !s.aw_held && !s.bvalid) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_held && !s.bvalid) begin
            next_s.w_held = 1'b1;
            next_s.wdata  = s_axi_wdata;
            next_s.wstrb  = s_axi_wstrb;
        end
        if (s.aw_held && s.w_held) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = `HCM_RESP_OKAY;
            unique case (s.aw_addr)
                `HCM_ADDR_CTRL: begin
                    next_s.ivl  = ctrl_m[`HCM_CTRL_IVL_MSB:`HCM_CTRL_IVL_LSB];
                    next_s.ener = ctrl_m[`HCM_CTRL_ENER_MSB:`HCM_CTRL_ENER_LSB];
                    next_s.dir  = ctrl_m[`HCM_CTRL_DIR_BIT];
                end
                `HCM_ADDR_RATIO: next_s.ratio = 16'(merge({16'h0, s.ratio}, s.wdata, s.wstrb));
                `HCM_ADDR_PHSEL: next_s.phsel = 16'(merge({16'h0, s.phsel}, s.wdata, s.wstrb));
                `HCM_ADDR_MASK:  next_s.mask  = 10'(merge({22'h0, s.mask}, s.wdata, s.wstrb));
                default: begin
                    if (bank(s.aw_addr) == `HCM_IDX_LIMIT) begin
                        next_s.limit[s.aw_addr[4:2]] = 16'(merge({16'h0, s.limit[s.aw_addr[4:2]]},
                                                                 s.wdata, s.wstrb));
                    end else if (!(s.aw_addr == `HCM_ADDR_STATUS || s.aw_addr == `HCM_ADDR_ALARM
                                   || bank(s.aw_addr) == `HCM_IDX_READING)) begin
                        next_s.bresp = `HCM_RESP_SLVERR;
                    end
                end
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // axi read; status read clears, new event wins
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `HCM_RESP_OKAY;
            next_s.rdata  = '0;
            unique case (s_axi_araddr)
                `HCM_ADDR_CTRL:   next_s.rdata = {11'h0, s.dir, s.ener, s.ivl};
                `HCM_ADDR_RATIO:  next_s.rdata = {16'h0, s.ratio};
                `HCM_ADDR_PHSEL:  next_s.rdata = {16'h0, s.phsel};
                `HCM_ADDR_STATUS: begin
                    next_s.rdata  = {22'h0, s.status};
                    next_s.status = '0;
                end
                `HCM_ADDR_MASK:   next_s.rdata = {22'h0, s.mask};
                `HCM_ADDR_ALARM:  next_s.rdata = {19'h0, s.slot, s.short_alarm, s.heat_alarm};
                default: begin
                    if (bank(s_axi_araddr) == `HCM_IDX_LIMIT) begin
                        next_s.rdata = {16'h0, s.limit[s_axi_araddr[4:2]]};
                    end else if (bank(s_axi_araddr) == `HCM_IDX_READING) begin
                        next_s.rdata = s.reading[s_axi_araddr[4:2]];
                    end else begin
                        next_s.rresp = `HCM_RESP_SLVERR;
                    end
                end
            endcase
        end
        next_s.status = next_s.status | ev;
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk) begin
        if (srst) begin
            s             <= '0;
            s.phase       <= hcm_pkg::HCM_IDLE;
            s.ivl         <= `HCM_RST_IVL;
            s.ener        <= `HCM_RST_ENER;
            s.ratio       <= `HCM_RST_RATIO;
            s.limit       <= {`HCM_OUTPUTS{`HCM_LIMIT_OFF}};
        end else begin
            s <= next_s;
        end
    end

    // outputs from state
    assign s_axi_awready        = !s.aw_held && !s.bvalid;
    assign s_axi_wready         = !s.w_held && !s.bvalid;
    assign s_axi_bvalid         = s.bvalid;
    assign s_axi_bresp          = s.bresp;
    assign s_axi_arready        = !s.rvalid;
    assign s_axi_rvalid         = s.rvalid;
    assign s_axi_rdata          = s.rdata;
    assign s_axi_rresp          = s.rresp;
    assign drive_out            = s.drv;
    assign current_alarm        = s.heat_alarm;
    assign shorted_switch_alarm = s.short_alarm;
    assign irq                  = |(s.status & s.mask);

endmodule
`default_nettype wire

/* dv/hcm_monitor_props.sv */
// checker: axi handshakes, gating, reset state
// assumes binding to the hcm_monitor ports
`timescale 1ns/1ns
`default_nettype none
module hcm_monitor_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // axi4-lite
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // heater side
    input wire logic [7:0]  drive_in,
    input wire logic [7:0]  monitor_enable_n,
    input wire logic [7:0]  drive_out,
    input wire logic [7:0]  current_alarm,
    input wire logic        shorted_switch_alarm,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    chk_read_ready: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready wrong");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write while bvalid");
    // one monitored output at most, or plain drive
    chk_gate_single: assert property (!$past(srst) |-> $countones(drive_out & $past(monitor_enable_n)) <= 1 || drive_out == $past(drive_in))
        else $error("two outputs on");
    chk_free_follow: assert property (!$past(srst) |-> ((drive_out ^ $past(drive_in)) & ~$past(monitor_enable_n)) == 8'h00)
        else $error("free output stuck");
    chk_reset_clear: assert property (disable iff (1'b0) srst |=> !s_axi_bvalid && !s_axi_rvalid && drive_out == 8'h00 && current_alarm == 8'h00 && !shorted_switch_alarm && !irq)
        else $error("reset not clean");
endmodule
`default_nettype wire

/* dv/hcm_ct_model.sv */
// partner: summing current transformer behind the switched heaters
// assumes bench-set heater and leak currents, microamps
`timescale 1ns/1ns
`default_nettype none
module hcm_ct_model (
    // clock
    input  wire logic             clk,
    // heaters
    input  wire logic [7:0]       drive_out,
    input  wire logic [7:0][15:0] heater_ua,
    input  wire logic [15:0]      leak_ua,
    // transformer
    output logic                  ct_valid,
    output logic [15:0]           ct_current_ua
);
    logic [15:0] sum;
    logic [15:0] last;
    logic [3:0]  age;
    initial begin
        ct_valid = 1'b0;
        age = 4'h0;
        last = 16'h0;
    end
    always_comb begin
        sum = leak_ua;
        for (int i = 0; i < 8; i++) if (drive_out[i]) sum = sum + heater_ua[i];
    end
    // settling overshoot: early samples read double
    always @(posedge clk) begin
        last <= sum;
        age <= (sum != last) ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
        ct_valid <= !ct_valid;
        ct_current_ua <= ct_valid ? ~sum : (age < 4'h5 ? sum << 1 : sum);
    end
endmodule
`default_nettype wire

/* dv/heating_current_monitor_test.sv */
// bench: two config rounds over all slots, short slot, irq mask
// assumes short tick and the ct model
`timescale 1ns/1ns
`default_nettype none
`include "hcm_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module heating_current_monitor_test;
    int               n_tests = 0;
    int               failures = 0;
    int               on_cnt = 0;
    logic             clk = 1'b0;
    logic             srst = 1'b1;
    logic             rnd = 1'b0;
    logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic             s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0]       s_axi_wstrb = 4'hf;
    logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, drive_in = 8'h00, monitor_enable_n = 8'hff;
    logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic             ct_valid, shorted_switch_alarm, irq;
    logic [1:0]       s_axi_bresp, s_axi_rresp, rs;
    logic [7:0]       drive_out, current_alarm;
    logic [15:0]      ct_current_ua, ratio, phsel, leak_ua = 16'h0;
    logic [7:0][15:0] heater_ua = '0, lim;
    hcm_pkg::hcm_phase_volt_t voltage_correction_line = '0;
    ////////////////////////////////////////////////////////////////////////
    hcm_monitor #(.TICK_CYCLES(10)) i_hcm_monitor (
        .clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .drive_in, .monitor_enable_n, .drive_out, .ct_valid, .ct_current_ua, .voltage_correction_line,
        .current_alarm, .shorted_switch_alarm, .irq
    );
    hcm_ct_model i_hcm_ct_model (.clk, .drive_out, .heater_ua, .leak_ua, .ct_valid, .ct_current_ua);
    always #5 clk = ~clk;
    always @(posedge clk) if (rnd) drive_in <= 8'($urandom);
    always @(posedge clk) if (!srst && drive_out != 8'h00) on_cnt <= on_cnt + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    function automatic logic [31:0] exp_rd(input logic [15:0] c, input logic [15:0] r, input logic [7:0] v);
        logic [63:0] p;
        p = ({48'h0, c} * r * (64'h100 - v)) >> 7;
        return (p > 64'hffffffff) ? 32'hffffffff : p[31:0];
    endfunction
    function automatic logic exp_al(input logic [31:0] x, input logic [15:0] l, input logic dir);
        longint lu;
        lu = longint'($signed(l)) * 100000;
        if (l == `HCM_LIMIT_OFF) return 1'b0;
        return dir ? (longint'(x) > lu) : (longint'(x) < lu);
    endfunction
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] exp_r, keep3;
        logic        al;
        logic [1:0]  sel;
        int          ivl, k_last;
        time         t_last;
        void'($urandom(32'h90fbac1e));
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`HCM_ADDR_CTRL, d, rs);
        `CHK(d, 32'h0000200a)
        rd(`HCM_ADDR_RATIO, d, rs);
        `CHK(d, 32'h000003e8)
        rd(`HCM_ADDR_LIMIT0 + 8'h1c, d, rs);
        `CHK(d[15:0], `HCM_LIMIT_OFF)
        rd(8'h18, d, rs);
        `CHK(rs, `HCM_RESP_SLVERR)
        wr(8'h18, 32'h1, rs);
        `CHK(rs, `HCM_RESP_SLVERR)
        $display("reset values done");
        for (int r = 0; r < 2; r++) begin
            if (r) `CHK(on_cnt, 240)
            ratio = r ? 16'($urandom_range(1500, 500)) : 16'd1000;
            phsel = r ? 16'h3024 : 16'h0000;
            ivl = r ? 1 : 2;
            rnd <= 1'(r);
            monitor_enable_n <= r ? 8'hf7 : 8'hff;
            leak_ua <= 16'($urandom_range(8, 1));
            for (int i = 0; i < 3; i++) voltage_correction_line.line[i] <= 8'($urandom_range(8'ha0, 8'h60));
            for (int i = 0; i < 8; i++) begin
                heater_ua[i] <= (r && i == 3) ? 16'h0 : 16'($urandom_range(999));
                lim[i] = (i == 5) ? `HCM_LIMIT_OFF : 16'($urandom_range(12));
                wr(`HCM_ADDR_LIMIT0 + 8'(4 * i), {16'h0, lim[i]}, rs);
            end
            wr(`HCM_ADDR_RATIO, {16'h0, ratio}, rs);
            wr(`HCM_ADDR_PHSEL, {16'h0, phsel}, rs);
            wr(`HCM_ADDR_MASK, 32'h3ff, rs);
            // round two: out of range, clamps to 1 s and 200 ms
            wr(`HCM_ADDR_CTRL, r ? {11'h0, 1'b1, 8'h01, 12'h000} : {11'h0, 1'b0, 8'h03, 12'h002}, rs);
            rd(`HCM_ADDR_STATUS, d, rs);
            k_last = -1;
            for (int k = 0; k < 9; k++) begin
                if (r && k == 3) begin
                    repeat (ivl * 100 + 40) @(posedge clk);
                    rd(`HCM_ADDR_STATUS, d, rs);
                    continue;
                end
                while (irq !== 1'b1) @(posedge clk);
                if (k_last >= 0) `CHK($time - t_last, time'(ivl * 1000 * (k - k_last)))
                t_last = $time;
                k_last = k;
                rd(`HCM_ADDR_STATUS, d, rs);
                if (k == 8) begin
                    `CHK(d[9:0], 10'h300)
                    `CHK(shorted_switch_alarm, 1'b1)
                end else begin
                    sel = phsel[2 * k +: 2];
                    exp_r = exp_rd(heater_ua[k] + leak_ua, ratio, sel == 2'h0 ? 8'h80 : voltage_correction_line.line[sel - 2'h1]);
                    al = exp_al(exp_r, lim[k], 1'(r));
                    `CHK(d[9:0], {2'b10, 8'(al) << k})
                    `CHK(current_alarm[k], al)
                    rd(`HCM_ADDR_READING0 + 8'(4 * k), d, rs);
                    `CHK(d, exp_r)
                    if (k == 3) keep3 = exp_r;
                end
                `CHK(irq, 1'b0)
            end
            $display("round %0d done", r);
        end
        rd(`HCM_ADDR_READING0 + 8'h0c, d, rs);
        `CHK(d, keep3)
        wr(`HCM_ADDR_MASK, 32'h0, rs);
        repeat (150) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(`HCM_ADDR_STATUS, d, rs);
        `CHK(d[9], 1'b1)
        $display("irq mask done");
        report_and_stop;
    end
    initial begin
        #100000;
        failures++;
        report_and_stop;
    end
endmodule
bind hcm_monitor hcm_monitor_props i_hcm_monitor_props (
    .clk, .srst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .drive_in,
    .monitor_enable_n, .drive_out, .current_alarm, .shorted_switch_alarm, .irq
);
`default_nettype wire
